// ### rtl/rtcsp_fifo.v
// synchronous fifo with valid and ready on both sides
// assumes one clock and an asynchronous active high reset
`timescale 1ns/100ps
module rtcsp_fifo #(
	parameter WIDTH = 11,
	parameter DEPTH = 16,
	parameter AW = 4
)(
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ff;
reg [AW:0] rd_ff;
wire do_wr;
wire do_rd;
////////////////////////////////////////////////////////////////
// one spare pointer bit tells full from empty
assign o_in_ready = (wr_ff[AW] == rd_ff[AW]) | (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
assign o_out_valid = (wr_ff != rd_ff);
assign o_out_data = mem[rd_ff[AW-1:0]];
assign do_wr = i_in_valid & o_in_ready;
assign do_rd = o_out_valid & i_out_ready;
// storage has no reset, only pointers are control state
always @(posedge i_clk)
begin
	if (do_wr)
	begin
		mem[wr_ff[AW-1:0]] <= i_in_data;
	end
end
// pointer update
always @(posedge i_clk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		wr_ff <= {(AW+1){1'b0}};
		rd_ff <= {(AW+1){1'b0}};
	end
	else
	begin
		if (do_wr)
		begin
			wr_ff <= wr_ff + 1'b1;
		end
		if (do_rd)
		begin
			rd_ff <= rd_ff + 1'b1;
		end
	end
end
endmodule

// ### rtl/rtcsp_map.vh
// constants of the rtc two-wire slave port
// assumes it is included by name from rtl files only
`ifndef RTCSP_MAP_VH
`define RTCSP_MAP_VH
// own slave address byte, direction bit zero
`define RTCSP_SLV_BYTE 8'hd0
// number of clock and calendar locations
`define RTCSP_NUM_LOC 8
`define RTCSP_LOC_RST 8'h00
`define RTCSP_FIFO_DEPTH 16
// bits in a byte, the ninth is acknowledge
`define RTCSP_BYTE_BITS 4'h8
// kinds of received byte
`define RTCSP_K_ADR 2'h0
`define RTCSP_K_WAD 2'h1
`define RTCSP_K_DAT 2'h2
`endif

// ### rtl/rtcsp_port.v
// two-wire slave port of a small rtc with eight bcd locations
// assumes scl and sda come from pins, sda is open drain outside,
// and a timekeeping block drives the update port on i_clk.
`timescale 1ns/100ps
`include "rtcsp_map.vh"
module rtcsp_port (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_scl,
	input wire i_sda,
	output wire o_sda_out,
	output wire o_sda_oe,
	input wire i_tk_we,
	input wire [2:0] i_tk_addr,
	input wire [7:0] i_tk_data,
	output wire o_wr_stb,
	output wire [2:0] o_wr_addr,
	output wire [7:0] o_wr_data,
	output wire o_busy
);
localparam ST_IDLE = 3'h0;
localparam ST_RX = 3'h1;
localparam ST_RACK = 3'h2;
localparam ST_TX = 3'h3;
localparam ST_MACK = 3'h4;
localparam ST_SKIP = 3'h5;
// pointer step, wraps after the control byte
function [2:0] rtcsp_inc;
	input [2:0] p;
	begin
		rtcsp_inc = p + 3'h1;
	end
endfunction
reg [7:0] mem [0:`RTCSP_NUM_LOC-1];
reg scl_s1_ff;
reg scl_s2_ff;
reg scl_d_ff;
reg sda_s1_ff;
reg sda_s2_ff;
reg sda_d_ff;
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [3:0] bit_ff;
reg [3:0] nxt_bit;
reg [7:0] sh_ff;
reg [7:0] nxt_sh;
reg [1:0] kind_ff;
reg [1:0] nxt_kind;
reg rd_ff;
reg nxt_rd;
reg nack_ff;
reg nxt_nack;
reg [2:0] ptr_ff;
reg [2:0] nxt_ptr;
reg oe_ff;
reg nxt_oe;
reg push_ff;
reg nxt_push;
reg [10:0] push_data_ff;
reg [10:0] nxt_push_data;
reg busy_ff;
reg wr_stb_ff;
reg [2:0] wr_addr_ff;
reg [7:0] wr_data_ff;
reg sda_out_ff;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;
wire fifo_in_ready;
wire fifo_out_valid;
wire fifo_out_ready;
wire [10:0] fifo_out_data;
wire [7:0] cur_byte;
integer i;
////////////////////////////////////////////////////////////////
// pin synchronisers; first stage feeds only the second
always @(posedge i_clk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		scl_s1_ff <= 1'b1;
		scl_s2_ff <= 1'b1;
		scl_d_ff <= 1'b1;
		sda_s1_ff <= 1'b1;
		sda_s2_ff <= 1'b1;
		sda_d_ff <= 1'b1;
	end
	else
	begin
		scl_s1_ff <= i_scl;
		scl_s2_ff <= scl_s1_ff;
		scl_d_ff <= scl_s2_ff;
		sda_s1_ff <= i_sda;
		sda_s2_ff <= sda_s1_ff;
		sda_d_ff <= sda_s2_ff;
	end
end
// edge and condition detection on the synchronised lines
assign scl_rise = scl_s2_ff & ~scl_d_ff;
assign scl_fall = ~scl_s2_ff & scl_d_ff;
assign start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
assign stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
assign cur_byte = mem[ptr_ff];
////////////////////////////////////////////////////////////////
// protocol engine; sda moves happen after an scl fall, except the release on a start or stop
always @*
begin
	nxt_state = state_ff;
	nxt_bit = bit_ff;
	nxt_sh = sh_ff;
	nxt_kind = kind_ff;
	nxt_rd = rd_ff;
	nxt_nack = nack_ff;
	nxt_ptr = ptr_ff;
	nxt_oe = oe_ff;
	nxt_push = 1'b0;
	nxt_push_data = push_data_ff;
	if (start_det)
	begin
		// repeated start keeps the pointer
		nxt_state = ST_RX;
		nxt_bit = 4'h0;
		nxt_kind = `RTCSP_K_ADR;
		nxt_oe = 1'b0;
	end
	else if (stop_det)
	begin
		nxt_state = ST_IDLE;
		nxt_bit = 4'h0;
		nxt_oe = 1'b0;
	end
	else
	begin
		case (state_ff)
		ST_RX:
		begin
			// sample on rise, bits sit still while scl high
			if (scl_rise && bit_ff < `RTCSP_BYTE_BITS)
			begin
				nxt_sh = {sh_ff[6:0], sda_s2_ff};
				nxt_bit = bit_ff + 4'h1;
			end
			else if (scl_fall && bit_ff == `RTCSP_BYTE_BITS)
			begin
				if (kind_ff == `RTCSP_K_ADR)
				begin
					if ({1'b0, sh_ff[7:1]} == (`RTCSP_SLV_BYTE >> 1))
					begin
						nxt_rd = sh_ff[0];
						nxt_oe = 1'b1;
						nxt_state = ST_RACK;
					end
					else
					begin
						nxt_state = ST_SKIP;
					end
				end
				else if (kind_ff == `RTCSP_K_WAD)
				begin
					// only the low bits select one of eight locations
					nxt_ptr = sh_ff[2:0];
					nxt_oe = 1'b1;
					nxt_state = ST_RACK;
				end
				else if (fifo_in_ready)
				begin
					nxt_push = 1'b1;
					nxt_push_data = {ptr_ff, sh_ff};
					nxt_ptr = rtcsp_inc(ptr_ff);
					nxt_oe = 1'b1;
					nxt_state = ST_RACK;
				end
				else
				begin
					// full buffer refuses the byte by withholding ack
					nxt_state = ST_SKIP;
				end
			end
		end
		ST_RACK:
		begin
			// ack held low across the whole ninth pulse
			if (scl_fall)
			begin
				nxt_oe = 1'b0;
				nxt_bit = 4'h0;
				if (kind_ff == `RTCSP_K_ADR && rd_ff)
				begin
					nxt_sh = cur_byte;
					nxt_oe = ~cur_byte[7];
					nxt_bit = 4'h1;
					nxt_state = ST_TX;
				end
				else
				begin
					// byte count is unbounded
					nxt_kind = (kind_ff == `RTCSP_K_ADR) ? `RTCSP_K_WAD : `RTCSP_K_DAT;
					nxt_state = ST_RX;
				end
			end
		end
		ST_TX:
		begin
			if (scl_fall)
			begin
				if (bit_ff < `RTCSP_BYTE_BITS)
				begin
					nxt_sh = {sh_ff[6:0], 1'b0};
					nxt_oe = ~sh_ff[6];
					nxt_bit = bit_ff + 4'h1;
				end
				else
				begin
					// let go for the master's ack bit
					nxt_oe = 1'b0;
					nxt_nack = 1'b1;
					nxt_state = ST_MACK;
				end
			end
		end
		ST_MACK:
		begin
			if (scl_rise)
			begin
				nxt_nack = sda_s2_ff;
				if (!sda_s2_ff)
				begin
					nxt_ptr = rtcsp_inc(ptr_ff);
				end
			end
			else if (scl_fall)
			begin
				if (!nack_ff)
				begin
					nxt_sh = cur_byte;
					nxt_oe = ~cur_byte[7];
					nxt_bit = 4'h1;
					nxt_state = ST_TX;
				end
				else
				begin
					nxt_oe = 1'b0;
					nxt_state = ST_SKIP;
				end
			end
		end
		default:
		begin
			// idle and skip wait for the next start only
			nxt_oe = 1'b0;
		end
		endcase
	end
end
////////////////////////////////////////////////////////////////
// engine state registers
always @(posedge i_clk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		state_ff <= ST_IDLE;
		bit_ff <= 4'h0;
		sh_ff <= 8'h00;
		kind_ff <= `RTCSP_K_ADR;
		rd_ff <= 1'b0;
		nack_ff <= 1'b1;
		ptr_ff <= 3'h0;
		oe_ff <= 1'b0;
		push_ff <= 1'b0;
		push_data_ff <= 11'h000;
		busy_ff <= 1'b0;
		sda_out_ff <= 1'b0;
	end
	else
	begin
		state_ff <= nxt_state;
		bit_ff <= nxt_bit;
		sh_ff <= nxt_sh;
		kind_ff <= nxt_kind;
		rd_ff <= nxt_rd;
		nack_ff <= nxt_nack;
		ptr_ff <= nxt_ptr;
		oe_ff <= nxt_oe;
		push_ff <= nxt_push;
		push_data_ff <= nxt_push_data;
		busy_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_SKIP);
		sda_out_ff <= 1'b0;
	end
end
////////////////////////////////////////////////////////////////
// written bytes wait here while timekeeping owns the array
rtcsp_fifo #(
	.WIDTH(11),
	.DEPTH(`RTCSP_FIFO_DEPTH),
	.AW(4)
) u_fifo (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_in_valid(push_ff),
	.o_in_ready(fifo_in_ready),
	.i_in_data(push_data_ff),
	.o_out_valid(fifo_out_valid),
	.i_out_ready(fifo_out_ready),
	.o_out_data(fifo_out_data)
);
// timekeeping update wins; bus writes stall in the fifo
assign fifo_out_ready = ~i_tk_we;
// location array
always @(posedge i_clk or posedge i_sys_rst)
begin
	if (i_sys_rst)
	begin
		for (i = 0; i < `RTCSP_NUM_LOC; i = i + 1)
		begin
			mem[i] <= `RTCSP_LOC_RST;
		end
		wr_stb_ff <= 1'b0;
		wr_addr_ff <= 3'h0;
		wr_data_ff <= 8'h00;
	end
	else
	begin
		wr_stb_ff <= 1'b0;
		if (i_tk_we)
		begin
			mem[i_tk_addr] <= i_tk_data;
		end
		else if (fifo_out_valid)
		begin
			mem[fifo_out_data[10:8]] <= fifo_out_data[7:0];
			wr_stb_ff <= 1'b1;
			wr_addr_ff <= fifo_out_data[10:8];
			wr_data_ff <= fifo_out_data[7:0];
		end
	end
end
////////////////////////////////////////////////////////////////
// outputs, all from flip-flops
assign o_sda_out = sda_out_ff;
assign o_sda_oe = oe_ff;
assign o_wr_stb = wr_stb_ff;
assign o_wr_addr = wr_addr_ff;
assign o_wr_data = wr_data_ff;
assign o_busy = busy_ff;
endmodule

// ### tb/rtcsp_master.sv
// bus master model that drives scl and sda of the two-wire port
// assumes the line is open drain with a pull-up, device pull is i_oe
`timescale 1ns/100ps
module rtcsp_master (
	input wire i_clk,
	input wire i_oe,
	output reg o_scl,
	output wire o_sda,
	output reg o_rv,
	output reg [8:0] o_res
);
	reg sda_ff;
	// wired and: a released line floats up to the pull-up level
	assign o_sda = sda_ff & ~i_oe;
	initial
	begin
		o_scl = 1'b1;
		sda_ff = 1'b1;
		o_rv = 1'b0;
		o_res = 9'h000;
	end
	////////////////
	task hp;
		repeat (4) @(posedge i_clk);
	endtask
	// sda moves one clock after scl falls, so no false condition is seen
	task bit1(input b, output r);
		@(posedge i_clk) sda_ff <= b;
		repeat (3) @(posedge i_clk);
		o_scl <= 1'b1;
		hp;
		r = o_sda;
		o_scl <= 1'b0;
	endtask
	// sda is released before scl rises, so a start works on an idle bus or as a repeated start
	task send_start;
		@(posedge i_clk) sda_ff <= 1'b1;
		hp;
		o_scl <= 1'b1;
		hp;
		sda_ff <= 1'b0;
		hp;
		o_scl <= 1'b0;
	endtask
	task send_stop;
		@(posedge i_clk) sda_ff <= 1'b0;
		hp;
		o_scl <= 1'b1;
		hp;
		sda_ff <= 1'b1;
		hp;
	endtask
	// n bits msb first; a full byte adds the ninth bit, a pulls it low
	task xfer(input [7:0] d, input a, input integer n);
		integer i;
		reg [7:0] r;
		reg k;
		r = 8'h00;
		for (i = 7; i > 7 - n; i = i - 1)
			bit1(d[i], r[i]);
		if (n == 8)
		begin
			bit1(~a, k);
			o_res <= {r, ~k};
			o_rv <= 1'b1;
			@(posedge i_clk) o_rv <= 1'b0;
		end
	endtask
endmodule

// ### tb/rtcsp_port_chk.sv
// assertions on the pins of the two-wire slave port
// assumes bus phases of at least four clocks from the master
`timescale 1ns/100ps
module rtcsp_port_chk (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_scl,
	input wire i_sda,
	input wire o_sda_out,
	input wire o_sda_oe,
	input wire i_tk_we,
	input wire [2:0] i_tk_addr,
	input wire [7:0] i_tk_data,
	input wire o_wr_stb,
	input wire [2:0] o_wr_addr,
	input wire [7:0] o_wr_data,
	input wire o_busy
);
	// one domain, so clock and reset are stated once
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	////////////////
	AST_OD_LOW: assert property (o_sda_out == 1'b0)
		else $error("sda out not low");
	AST_OE_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda drive moved while scl high");
	AST_ACK_HOLD: assert property ($rose(i_scl) && o_sda_oe |=> o_sda_oe [*3])
		else $error("sda pull dropped in scl high");
	// the past term keeps a pull made as scl rises from looking like a condition
	AST_START_BUSY: assert property (i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:6] o_busy)
		else $error("start not taken");
	AST_STOP_IDLE: assert property (i_scl && $past(i_scl) && $rose(i_sda)
		|-> ##[1:6] (!o_busy && !o_sda_oe))
		else $error("stop did not end transfer");
	AST_IDLE_QUIET: assert property (!o_busy |-> !o_sda_oe)
		else $error("sda pulled while idle");
	AST_WR_HOLD: assert property (!o_wr_stb |-> $stable({o_wr_addr, o_wr_data}))
		else $error("write outputs moved without strobe");
	AST_TK_FIRST: assert property (i_tk_we [*2] |=> !o_wr_stb)
		else $error("bus write beat update port");
	cover property (o_wr_stb);
	cover property ($rose(i_scl) && o_sda_oe);
	cover property (o_busy && i_tk_we);
endmodule
bind rtcsp_port rtcsp_port_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.i_tk_we(i_tk_we), .i_tk_addr(i_tk_addr), .i_tk_data(i_tk_data),
	.o_wr_stb(o_wr_stb), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
	.o_busy(o_busy));

// ### tb/rtcsp_port_tb.sv
// self-checking bench of the two-wire slave port with a master model
// assumes the master model and the bound checker are compiled first
`timescale 1ns/100ps
module rtcsp_port_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg tk_we = 1'b0;
	reg [2:0] tk_a = 3'h0;
	reg [7:0] tk_d = 8'h00;
	wire scl, sda, oe, stb, busy, rv;
	wire [2:0] wa;
	wire [7:0] wd;
	wire [8:0] rr;
	integer miscompares = 0;
	integer samples_checked = 0;
	integer i, n;
	reg [8:0] eq[$];
	reg [10:0] wq[$];
	reg [7:0] mem[0:7];
	reg [7:0] v;
	reg [2:0] p = 3'h0;
	always #4 clk = ~clk;
	rtcsp_port dut (.i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda),
		.o_sda_out(), .o_sda_oe(oe), .i_tk_we(tk_we), .i_tk_addr(tk_a),
		.i_tk_data(tk_d), .o_wr_stb(stb), .o_wr_addr(wa), .o_wr_data(wd), .o_busy(busy));
	rtcsp_master m (.i_clk(clk), .i_oe(oe), .o_scl(scl), .o_sda(sda), .o_rv(rv), .o_res(rr));
	////////////////
	function [7:0] bcd(input [31:0] r);
		bcd = {r[7:4] % 4'ha, r[3:0] % 4'ha};
	endfunction
	task chk(input [10:0] s, input [10:0] e);
		samples_checked = samples_checked + 1;
		if (s !== e)
		begin
			miscompares = miscompares + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task close_out;
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one byte from the master, e is the ack it should see
	task wb(input [7:0] d, input e);
		eq.push_back({d, e});
		m.xfer(d, 1'b0, 8);
	endtask
	task wdat(input [7:0] d);
		mem[p] = d;
		wq.push_back({p, d});
		p = p + 3'h1;
		wb(d, 1'b1);
	endtask
	// read one byte, the pointer only moves on a master ack
	task rb(input a);
		eq.push_back({mem[p], a});
		m.xfer(8'hff, a, 8);
		if (a)
			p = p + 3'h1;
	endtask
	task seek(input [7:0] w);
		m.send_start;
		wb(8'hd0, 1'b1);
		wb(w, 1'b1);
		p = w[2:0];
	endtask
	task rd_go;
		m.send_start;
		wb(8'hd1, 1'b1);
	endtask
	// results are compared in the order they were noted
	always @(posedge clk)
	begin
		if (rv)
			chk(rr, eq.pop_front());
		if (stb)
			chk({wa, wd}, wq.pop_front());
	end
	initial
	begin
		#300000;
		miscompares = miscompares + 1;
		close_out;
	end
	////////////////
	initial
	begin
		n = $urandom(32'h7040);
		for (i = 0; i < 8; i = i + 1)
			mem[i] = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// ten bytes from a random place run past the wrap
		seek(8'($urandom));
		for (i = 0; i < 10; i = i + 1)
			wdat(bcd($urandom));
		// repeated start, read ends with a missing ack
		seek(8'($urandom));
		rd_go;
		rb(1'b1);
		rb(1'b1);
		rb(1'b0);
		m.send_stop;
		// update port write, then a read with no word address
		v = bcd($urandom);
		tk_we <= 1'b1;
		tk_a <= p;
		tk_d <= v;
		@(posedge clk);
		tk_we <= 1'b0;
		mem[p] = v;
		rd_go;
		rb(1'b1);
		rb(1'b0);
		m.send_stop;
		// foreign addresses get no ack, nor do the bytes after them
		for (i = 0; i < 4; i = i + 1)
		begin
			v = $urandom;
			if (v[7:1] == 7'h68)
				v = v ^ 8'h02;
			m.send_start;
			wb(v, 1'b0);
			wb(8'h00, 1'b0);
			m.send_stop;
		end
		// stop in mid word address leaves the pointer alone
		m.send_start;
		wb(8'hd0, 1'b1);
		m.xfer(8'h05, 1'b0, 3);
		m.send_stop;
		rd_go;
		rb(1'b0);
		m.send_stop;
		// stalled drain: sixteen bytes fill the buffer, the next is refused
		tk_we <= 1'b1;
		seek(8'h00);
		for (i = 0; i < 16; i = i + 1)
			wdat(bcd($urandom));
		wb(8'h11, 1'b0);
		m.send_stop;
		tk_we <= 1'b0;
		n = 0;
		while (wq.size() != 0 && n < 200)
		begin
			@(posedge clk);
			n = n + 1;
		end
		chk(wq.size(), 11'h000);
		// all eight locations read back in order
		seek(8'h00);
		rd_go;
		for (i = 0; i < 7; i = i + 1)
			rb(1'b1);
		rb(1'b0);
		m.send_stop;
		repeat (20) @(posedge clk);
		close_out;
	end
endmodule
